// ---- bench/tb_top.sv ----
// tb_top: self-checking bench for tcr_thermal_regs
// assumes: the host model makes all register traffic
`default_nettype none
module tb_top
  import tcr_pkg::*;
  ;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clk = 1'b0;
  logic        arst_n = 1'b0;
  logic [7:0]  addr, wdata, rdata, therm;
  logic        wr, rd, rvalid, susp;
  logic [12:0] vin, vout;
  logic [9:0]  iin, iout;
  logic [2:0]  zone;
  int          failures = 0;
  int          n_checks = 0;
  logic [7:0]  ra [8] = '{8'h61, 8'h62, 8'h63, 8'h64, 8'h65, 8'h6F, 8'h66, 8'h00};
  logic [7:0]  rv [8] = '{8'h34, 8'h7C, 8'h6D, 8'h38, 8'h27, TCR_PART_ID_DEF, 8'h00, 8'h00};
  logic [7:0]  zt [7] = '{8'h80, 8'h7C, 8'h6E, 8'h6D, 8'h38, 8'h27, 8'h26};
  int          ze [7] = '{0, 1, 1, 2, 2, 3, 4};
  always #12.5 clk = ~clk;
  tcr_host_model i_host (.clk_in(clk), .rvalid_in(rvalid), .rdata_in(rdata), .addr_out(addr),
    .wr_out(wr), .wdata_out(wdata), .rd_out(rd));
  tcr_thermal_regs i_dut (.CLK_IN(clk), .ARST_N_IN(arst_n), .REG_ADDR_IN(addr), .REG_WR_IN(wr),
    .REG_WDATA_IN(wdata), .REG_RD_IN(rd), .REG_RDATA_OUT(rdata), .REG_RVALID_OUT(rvalid),
    .THERMISTOR_IN(therm), .VREG_TARGET_IN(vin), .FAST_CHARGE_CURRENT_IN(iin), .VREG_TARGET_OUT(vout),
    .FAST_CHARGE_CURRENT_OUT(iout), .ZONE_OUT(zone), .CHARGE_SUSPEND_OUT(susp));
  task automatic final_report();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("Error t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    logic       ok;
    i_host.rd(a, d, ok);
    if (ok !== 1'b1) begin
      failures++;
      final_report();
    end
    chk({8'h00, d}, {8'h00, exp});
  endtask
  // zone output lags the reading, so let the path settle
  task automatic settle(input logic [7:0] t);
    @(posedge clk);
    #2;
    therm = t;
    repeat (3) @(posedge clk);
    #2;
  endtask
  initial begin
    therm = 8'h50;
    vin = 13'd4200;
    iin = 10'd1001;
    repeat (6) @(posedge clk);
    #2;
    arst_n = 1'b1;
    for (int k = 0; k < 8; k++) rchk(ra[k], rv[k]);
    i_host.wr(8'h6F, 8'hFF);
    rchk(8'h6F, TCR_PART_ID_DEF);
    i_host.wr(8'h66, 8'hFF);
    rchk(8'h66, 8'h00);
    for (int k = 0; k < 5; k++) begin
      i_host.wr(ra[k], ~rv[k]);
      rchk(ra[k], ~rv[k]);
      i_host.wr(ra[k], rv[k]);
    end
    for (int k = 0; k < 7; k++) begin
      settle(zt[k]);
      chk(16'(zone), 16'(ze[k]));
      chk(16'(susp), 16'(ze[k] == 0 || ze[k] == 4));
    end
    for (int c = 0; c < 8; c++) begin
      i_host.wr(8'h61, {1'b0, 3'(c), 1'b0, 3'(c)});
      settle(8'h30);
      chk(16'(vout), 16'(4200 - 50 * c));
      chk(16'(iout), 16'(1001 * (8 - c) / 8));
      settle(8'h70);
      chk(16'(vout), 16'd4200);
      chk(16'(iout), 16'(1001 * (8 - c) / 8));
    end
    vin = 13'd100;
    settle(8'h30);
    chk(16'(vout), 16'd0);
    final_report();
  end
endmodule // tb_top
`default_nettype wire

// ---- bench/tcr_host_model.sv ----
// tcr_host_model: bus host seen as one-cycle register strobes
// assumes: strobes change 2 ns after a rising edge
`default_nettype none
module tcr_host_model (
  input  wire logic       clk_in,
  input  wire logic       rvalid_in,
  input  wire logic [7:0] rdata_in,
  output var  logic [7:0] addr_out,
  output var  logic       wr_out,
  output var  logic [7:0] wdata_out,
  output var  logic       rd_out
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    addr_out = 8'h00;
    wdata_out = 8'h00;
    wr_out = 1'b0;
    rd_out = 1'b0;
  end
  // released lines get the inverse so stale values cannot pass
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_in);
    #2;
    addr_out = a;
    wdata_out = d;
    wr_out = 1'b1;
    @(posedge clk_in);
    #2;
    wr_out = 1'b0;
    addr_out = ~a;
    wdata_out = ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
    @(posedge clk_in);
    #2;
    addr_out = a;
    rd_out = 1'b1;
    @(posedge clk_in);
    #2;
    rd_out = 1'b0;
    addr_out = ~a;
    ok = 1'b0;
    d = 8'h00;
    for (int n = 0; n < 4 && !ok; n++) begin
      if (rvalid_in === 1'b1) begin
        ok = 1'b1;
        d = rdata_in;
      end else begin
        @(posedge clk_in);
        #1;
      end
    end
  endtask
endmodule // tcr_host_model
`default_nettype wire

// ---- bench/tcr_props.sv ----
// tcr_props: port assertions for tcr_thermal_regs
// assumes: bound to every tcr_thermal_regs instance
`default_nettype none
module tcr_props
  import tcr_pkg::*;
  #(parameter int VREG_W = 13, parameter int FAST_CHARGE_CURRENT_W = 10, parameter logic [7:0] PART_ID = TCR_PART_ID_DEF) (
  input wire logic              CLK_IN,
  input wire logic              ARST_N_IN,
  input wire logic [7:0]        REG_ADDR_IN,
  input wire logic              REG_RD_IN,
  input wire logic [7:0]        REG_RDATA_OUT,
  input wire logic              REG_RVALID_OUT,
  input wire logic [VREG_W-1:0] VREG_TARGET_IN,
  input wire logic [FAST_CHARGE_CURRENT_W-1:0] FAST_CHARGE_CURRENT_IN,
  input wire logic [VREG_W-1:0] VREG_TARGET_OUT,
  input wire logic [FAST_CHARGE_CURRENT_W-1:0] FAST_CHARGE_CURRENT_OUT,
  input wire logic [2:0]        ZONE_OUT,
  input wire logic              CHARGE_SUSPEND_OUT
);
  timeunit 1ns;
  timeprecision 100ps;
  logic unmapped;
  assign unmapped = !(REG_ADDR_IN inside {[8'h61:8'h65], 8'h6F});
  default clocking @(posedge CLK_IN); endclocking
  default disable iff (!ARST_N_IN);
  // ----
  // register port
  // ----
  a_rd_valid_next: assert property (REG_RD_IN |=> REG_RVALID_OUT) else $error("read valid missing");
  a_valid_no_rd: assert property (!REG_RD_IN |=> !REG_RVALID_OUT) else $error("stray read valid");
  a_rdata_holds: assert property (!REG_RD_IN |=> $stable(REG_RDATA_OUT)) else $error("read data moved");
  a_id_read: assert property (REG_RD_IN && REG_ADDR_IN == 8'h6F |=> REG_RDATA_OUT == PART_ID)
    else $error("part id read wrong");
  a_unmapped_zero: assert property (REG_RD_IN && unmapped |=> REG_RDATA_OUT == 8'h00)
    else $error("unmapped read not zero");
  // ----
  // derating path
  // ----
  a_suspend_zone: assert property (CHARGE_SUSPEND_OUT == (ZONE_OUT == 3'h0 || ZONE_OUT == 3'h4))
    else $error("suspend disagrees with zone");
  // reset guard: outputs lag the inputs by one edge after release
  a_vreg_pass: assert property ($past(ARST_N_IN) && ZONE_OUT != 3'h3 && $stable(ZONE_OUT)
    && $stable(VREG_TARGET_IN) |-> VREG_TARGET_OUT == VREG_TARGET_IN) else $error("target altered");
  a_fast_charge_current_pass: assert property ($past(ARST_N_IN) && ZONE_OUT inside {3'h0, 3'h2, 3'h4} && $stable(ZONE_OUT)
    && $stable(FAST_CHARGE_CURRENT_IN) |-> FAST_CHARGE_CURRENT_OUT == FAST_CHARGE_CURRENT_IN)
    else $error("current altered");
  c_id_read: cover property (REG_RD_IN && REG_ADDR_IN == 8'h6F);
  c_warm: cover property (ZONE_OUT == 3'h3);
  c_suspend: cover property (CHARGE_SUSPEND_OUT);
endmodule // tcr_props
bind tcr_thermal_regs tcr_props #(.VREG_W(VREG_W), .FAST_CHARGE_CURRENT_W(FAST_CHARGE_CURRENT_W), .PART_ID(PART_ID)) i_props (
  .CLK_IN(CLK_IN), .ARST_N_IN(ARST_N_IN), .REG_ADDR_IN(REG_ADDR_IN), .REG_RD_IN(REG_RD_IN),
  .REG_RDATA_OUT(REG_RDATA_OUT), .REG_RVALID_OUT(REG_RVALID_OUT), .VREG_TARGET_IN(VREG_TARGET_IN),
  .FAST_CHARGE_CURRENT_IN(FAST_CHARGE_CURRENT_IN), .VREG_TARGET_OUT(VREG_TARGET_OUT),
  .FAST_CHARGE_CURRENT_OUT(FAST_CHARGE_CURRENT_OUT), .ZONE_OUT(ZONE_OUT), .CHARGE_SUSPEND_OUT(CHARGE_SUSPEND_OUT));
`default_nettype wire

// ---- design/tcr_pkg.sv ----
// tcr_pkg: register map, reset values, field positions and scale figures
// of the thermal charge configuration slice.
// assumes: one 8-bit register address space driven by the serial bus slave.
`default_nettype none

package tcr_pkg;

  // --------------------------------------------------------------------------
  // register offsets
  // --------------------------------------------------------------------------
  localparam logic [7:0] TCR_OFS_REDUCTION = 8'h61;
  localparam logic [7:0] TCR_OFS_COLD      = 8'h62;
  localparam logic [7:0] TCR_OFS_COOL      = 8'h63;
  localparam logic [7:0] TCR_OFS_WARM      = 8'h64;
  localparam logic [7:0] TCR_OFS_HOT       = 8'h65;
  localparam logic [7:0] TCR_OFS_PART_ID   = 8'h6F;

  // --------------------------------------------------------------------------
  // reset values
  // --------------------------------------------------------------------------
  localparam logic [7:0] TCR_RST_REDUCTION = 8'h34;
  localparam logic [7:0] TCR_RST_COLD      = 8'h7C;
  localparam logic [7:0] TCR_RST_COOL      = 8'h6D;
  localparam logic [7:0] TCR_RST_WARM      = 8'h38;
  localparam logic [7:0] TCR_RST_HOT       = 8'h27;
  // value is arbitrary, not that of any real part
  localparam logic [7:0] TCR_PART_ID_DEF   = 8'h5A;
  localparam logic [7:0] TCR_UNMAPPED_READ = 8'h00;

  // --------------------------------------------------------------------------
  // field positions in the reduction register
  // --------------------------------------------------------------------------
  localparam int TCR_VRED_MSB = 6;
  localparam int TCR_VRED_LSB = 4;
  localparam int TCR_ISCL_MSB = 2;
  localparam int TCR_ISCL_LSB = 0;

  // --------------------------------------------------------------------------
  // scale figures
  // --------------------------------------------------------------------------
  localparam int TCR_VRED_STEP_MV = 50;   // per code of warm_voltage_reduction
  localparam int TCR_ISCL_EIGHTHS = 8;    // current scale is in eighths
  localparam int TCR_ISCL_SHIFT   = 3;    // log2 of the eighths

  typedef enum {
    TCR_ZONE_COLD,
    TCR_ZONE_COOL,
    TCR_ZONE_NORMAL,
    TCR_ZONE_WARM,
    TCR_ZONE_HOT
  } tcr_zone_e;

endpackage : tcr_pkg

`default_nettype wire

// ---- design/tcr_thermal_regs.sv ----
// tcr_thermal_regs: thermal charge configuration registers and the
// regulation target and current derating they steer.
// assumes: the serial bus slave gives one-cycle write and read strobes on CLK_IN;
// the measurement front end gives a same-clock digitized thermistor code.
`default_nettype none

module tcr_thermal_regs
  import tcr_pkg::*;
  #(
  parameter int         VREG_W  = 13,   // regulation target in mV
  parameter int         FAST_CHARGE_CURRENT_W  = 10,   // fast-charge current code width
  parameter int         ADC_W   = 8,
  parameter logic [7:0] PART_ID = TCR_PART_ID_DEF
) (
  input  wire logic              CLK_IN,
  input  wire logic              ARST_N_IN,
  input  wire logic [7:0]        REG_ADDR_IN,
  input  wire logic              REG_WR_IN,
  input  wire logic [7:0]        REG_WDATA_IN,
  input  wire logic              REG_RD_IN,
  output var  logic [7:0]        REG_RDATA_OUT,
  output var  logic              REG_RVALID_OUT,
  input  wire logic [ADC_W-1:0]  THERMISTOR_IN,
  input  wire logic [VREG_W-1:0] VREG_TARGET_IN,
  input  wire logic [FAST_CHARGE_CURRENT_W-1:0] FAST_CHARGE_CURRENT_IN,
  output var  logic [VREG_W-1:0] VREG_TARGET_OUT,
  output var  logic [FAST_CHARGE_CURRENT_W-1:0] FAST_CHARGE_CURRENT_OUT,
  output var  logic [2:0]        ZONE_OUT,
  output var  logic              CHARGE_SUSPEND_OUT
);

  // --------------------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------------------
  function automatic logic [VREG_W-1:0] vred_mv(input logic [2:0] code);
    vred_mv = VREG_W'(int'(code) * TCR_VRED_STEP_MV);
  endfunction

  function automatic logic [FAST_CHARGE_CURRENT_W-1:0] iscale(input logic [FAST_CHARGE_CURRENT_W-1:0] i, input logic [2:0] code);
    logic [FAST_CHARGE_CURRENT_W+3:0] prod;
    prod = (FAST_CHARGE_CURRENT_W + 4)'(i) * (FAST_CHARGE_CURRENT_W + 4)'(TCR_ISCL_EIGHTHS - int'(code));
    iscale = prod[FAST_CHARGE_CURRENT_W+TCR_ISCL_SHIFT-1:TCR_ISCL_SHIFT];
  endfunction

  function automatic logic [2:0] zone_code(input tcr_zone_e z);
    zone_code = 3'(z);
  endfunction

  // --------------------------------------------------------------------------
  // register file
  // --------------------------------------------------------------------------
  logic [7:0] reduction_q;
  logic [7:0] cold_q;
  logic [7:0] cool_q;
  logic [7:0] warm_q;
  logic [7:0] hot_q;

  // reserved bits 7 and 3 are stored like any other bit
  always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      reduction_q <= TCR_RST_REDUCTION;
    end else if (REG_WR_IN && REG_ADDR_IN == TCR_OFS_REDUCTION) begin
      reduction_q <= REG_WDATA_IN;
    end
  end

  always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      cold_q <= TCR_RST_COLD;
      cool_q <= TCR_RST_COOL;
      warm_q <= TCR_RST_WARM;
      hot_q  <= TCR_RST_HOT;
    end else if (REG_WR_IN) begin
      unique case (REG_ADDR_IN)
        TCR_OFS_COLD: begin
          cold_q <= REG_WDATA_IN;
        end
        TCR_OFS_COOL: begin
          cool_q <= REG_WDATA_IN;
        end
        TCR_OFS_WARM: begin
          warm_q <= REG_WDATA_IN;
        end
        TCR_OFS_HOT: begin
          hot_q <= REG_WDATA_IN;
        end
        default: begin
        end
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // read port
  // --------------------------------------------------------------------------
  logic [7:0] rdata_d;

  // unmapped offsets read as zero rather than echoing a neighbour
  always_comb begin
    unique case (REG_ADDR_IN)
      TCR_OFS_REDUCTION: begin
        rdata_d = reduction_q;
      end
      TCR_OFS_COLD: begin
        rdata_d = cold_q;
      end
      TCR_OFS_COOL: begin
        rdata_d = cool_q;
      end
      TCR_OFS_WARM: begin
        rdata_d = warm_q;
      end
      TCR_OFS_HOT: begin
        rdata_d = hot_q;
      end
      TCR_OFS_PART_ID: begin
        rdata_d = PART_ID;
      end
      default: begin
        rdata_d = TCR_UNMAPPED_READ;
      end
    endcase
  end

  // read data held until the next read
  always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      REG_RDATA_OUT  <= TCR_UNMAPPED_READ;
      REG_RVALID_OUT <= 1'b0;
    end else begin
      REG_RVALID_OUT <= REG_RD_IN;
      if (REG_RD_IN) begin
        REG_RDATA_OUT <= rdata_d;
      end
    end
  end

  // --------------------------------------------------------------------------
  // zone classification
  // --------------------------------------------------------------------------
  tcr_zone_if #(.ADC_W(ADC_W)) zif ();

  assign zif.cold_threshold_code = cold_q;
  assign zif.cool_threshold_code = cool_q;
  assign zif.warm_threshold_code = warm_q;
  assign zif.hot_threshold_code  = hot_q;
  assign zif.thermistor_input    = THERMISTOR_IN;

  tcr_zone_classify u_classify (
    .zif (zif.classifier)
  );

  // --------------------------------------------------------------------------
  // derating
  // --------------------------------------------------------------------------
  logic [2:0]        warm_voltage_reduction;
  logic [2:0]        temp_current_scale;
  logic [VREG_W-1:0] vred;
  logic              is_warm;
  logic              derate_current;

  assign warm_voltage_reduction = reduction_q[TCR_VRED_MSB:TCR_VRED_LSB];
  assign temp_current_scale     = reduction_q[TCR_ISCL_MSB:TCR_ISCL_LSB];
  assign vred                   = vred_mv(warm_voltage_reduction);
  assign is_warm                = zif.zone == TCR_ZONE_WARM;
  // current is derated in both the cool and warm zones
  assign derate_current         = is_warm || zif.zone == TCR_ZONE_COOL;

  // target saturates at zero so a low setpoint cannot wrap round
  always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      VREG_TARGET_OUT <= '0;
    end else if (is_warm) begin
      if (VREG_TARGET_IN > vred) begin
        VREG_TARGET_OUT <= VREG_TARGET_IN - vred;
      end else begin
        VREG_TARGET_OUT <= '0;
      end
    end else begin
      VREG_TARGET_OUT <= VREG_TARGET_IN;
    end
  end

  always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      FAST_CHARGE_CURRENT_OUT <= '0;
    end else if (derate_current) begin
      FAST_CHARGE_CURRENT_OUT <= iscale(FAST_CHARGE_CURRENT_IN, temp_current_scale);
    end else begin
      FAST_CHARGE_CURRENT_OUT <= FAST_CHARGE_CURRENT_IN;
    end
  end

  // --------------------------------------------------------------------------
  // zone report
  // --------------------------------------------------------------------------
  // zone and suspend launch on the same edge as the derated outputs
  always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      ZONE_OUT <= zone_code(TCR_ZONE_NORMAL);
    end else begin
      ZONE_OUT <= zone_code(zif.zone);
    end
  end

  // suspend only at the extremes; cool and warm merely derate
  always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      CHARGE_SUSPEND_OUT <= 1'b0;
    end else begin
      CHARGE_SUSPEND_OUT <= zif.zone == TCR_ZONE_COLD || zif.zone == TCR_ZONE_HOT;
    end
  end

endmodule // tcr_thermal_regs

`default_nettype wire

// ---- design/tcr_zone_classify.sv ----
// tcr_zone_classify: combinational sort of the thermistor reading into zones.
// assumes: thresholds ordered cold > cool > warm > hot; reading is same-clock logic.
`default_nettype none

module tcr_zone_classify
  import tcr_pkg::*;
  (
  tcr_zone_if.classifier zif
);

  // higher voltage means colder battery; ties fall to the milder zone
  always_comb begin
    if (zif.thermistor_input > zif.cold_threshold_code) begin
      zif.zone = TCR_ZONE_COLD;
    end else if (zif.thermistor_input > zif.cool_threshold_code) begin
      zif.zone = TCR_ZONE_COOL;
    end else if (zif.thermistor_input < zif.hot_threshold_code) begin
      zif.zone = TCR_ZONE_HOT;
    end else if (zif.thermistor_input < zif.warm_threshold_code) begin
      zif.zone = TCR_ZONE_WARM;
    end else begin
      zif.zone = TCR_ZONE_NORMAL;
    end
  end

endmodule // tcr_zone_classify

`default_nettype wire

// ---- design/tcr_zone_if.sv ----
// tcr_zone_if: carries thresholds and reading to the zone classifier and
// the zone back to the register slice.
// assumes: both ends on CLK_IN.
`default_nettype none

interface tcr_zone_if
  import tcr_pkg::*;
  #(parameter int ADC_W = 8);
  logic [7:0]       cold_threshold_code;
  logic [7:0]       cool_threshold_code;
  logic [7:0]       warm_threshold_code;
  logic [7:0]       hot_threshold_code;
  logic [ADC_W-1:0] thermistor_input;
  tcr_zone_e        zone;

  modport owner (output cold_threshold_code, cool_threshold_code, warm_threshold_code,
                 hot_threshold_code, thermistor_input, input zone);
  modport classifier (input cold_threshold_code, cool_threshold_code, warm_threshold_code,
                      hot_threshold_code, thermistor_input, output zone);
endinterface : tcr_zone_if

`default_nettype wire
